/* File: rtl/osc_ctrl_pkg.sv */
/*
 * Constants for the oscillator source select block: register offsets,
 * field positions, source codes, unlock keys and timing.
 * Assumes a 32-bit APB bus with byte addresses.
 */
package osc_ctrl_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFFSET_CONTROL = 8'h00;
	localparam logic [7:0] OFFSET_KEY = 8'h04;
	localparam logic [7:0] OFFSET_EVENT_STATUS = 8'h08;
	localparam logic [7:0] OFFSET_EVENT_MASK = 8'h0C;

	// ---------------------------------------------------------------
	// Field positions inside oscillator_control
	// ---------------------------------------------------------------
	localparam int ACTIVE_LSB = 12;
	localparam int REQUESTED_LSB = 8;
	localparam int CLOCK_LOCK_BIT = 7;
	localparam int IO_LOCK_BIT = 6;
	localparam int PLL_LOCK_BIT = 5;
	localparam int FAIL_FLAG_BIT = 3;
	localparam int SWITCH_REQUEST_BIT = 0;

	// Event bits in the status and mask registers
	localparam int EVENT_SWITCH_DONE = 0;
	localparam int EVENT_SWITCH_REJECTED = 1;
	localparam int EVENT_CLOCK_FAIL = 2;
	localparam int EVENT_COUNT = 3;

	// ---------------------------------------------------------------
	// Clock source codes
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FAST_RC_SOURCE = 3'h0,
		FAST_RC_PLL_MODE = 3'h1,
		PRIMARY_SOURCE = 3'h2,
		PRIMARY_PLL_MODE = 3'h3,
		RESERVED_SOURCE = 3'h4,
		LOW_POWER_RC_SOURCE = 3'h5,
		FAST_RC_DIV16_SOURCE = 3'h6,
		FAST_RC_DIVN_SOURCE = 3'h7
	} source_code_type;

	// ---------------------------------------------------------------
	// Unlock keys and timing
	// ---------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h5A;
	localparam logic [7:0] KEY_SECOND = 8'hA5;
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int UNLOCK_WINDOW_NS = 40;
	localparam int UNLOCK_WINDOW_CYCLES = UNLOCK_WINDOW_NS / CLOCK_PERIOD_NS;
	localparam int SWITCH_TIME_NS = 64;
	localparam int SWITCH_CYCLES =
		(SWITCH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam logic [2:0] RESET_SOURCE = 3'h0;

endpackage : osc_ctrl_pkg

/* File: rtl/osc_unlock_seq.sv */
/*
 * Unlock sequence tracker: two key writes in a row open a short window
 * in which one write to the control register is allowed.
 * Assumes single-cycle write strobes from the bus slave on the same clock.
 */
`timescale 1ns/1ps

module osc_unlock_seq #(
	parameter int WINDOW_CYCLES = osc_ctrl_pkg::UNLOCK_WINDOW_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic key_write,
	input wire logic [7:0] key_data,
	input wire logic other_write,
	input wire logic control_write,
	output logic unlocked
);

	typedef enum logic [1:0] {
		WAIT_FIRST = 2'h0,
		WAIT_SECOND = 2'h1,
		OPEN = 2'h2
	} unlock_state_type;

	unlock_state_type state;
	logic [7:0] window_count;

	// Key sequence; any stray write or expiry closes the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= WAIT_FIRST;
			window_count <= 8'h00;
		end else begin
			case (state)
				WAIT_FIRST: begin
					if (key_write && key_data == osc_ctrl_pkg::KEY_FIRST)
						state <= WAIT_SECOND;
				end
				WAIT_SECOND: begin
					if (key_write && key_data == osc_ctrl_pkg::KEY_SECOND) begin
						state <= OPEN;
						window_count <= 8'(WINDOW_CYCLES);
					end else if (key_write || other_write || control_write) begin
						state <= WAIT_FIRST;
					end
				end
				OPEN: begin
					if (control_write || key_write || other_write ||
							window_count == 8'h00)
						state <= WAIT_FIRST;
					else
						window_count <= window_count - 8'h01;
				end
				default: state <= WAIT_FIRST;
			endcase
		end
	end

	assign unlocked = (state == OPEN);

endmodule : osc_unlock_seq

/* File: rtl/osc_ctrl.sv */
/*
 * Oscillator source select control with APB register access.
 * Assumes pclk is the system clock, osc_fail_pin and pll_lock_pin are
 * asynchronous, and strap_source_code is stable at reset release.
 */
//
// Contract
// - The active-source field is read-only and reports the source in use.
// - The requested-source field is writable, same coding, 100 reserved.
// - Control writes take effect only right after the unlock key sequence.
// - A direct switch between the two PLL modes is refused.
// - Writing one to the clock-fail flag acts as a real failure with trap.
`timescale 1ns/1ps

module osc_ctrl #(
	parameter int SWITCH_CYCLES = osc_ctrl_pkg::SWITCH_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] strap_source_code,
	input wire logic osc_fail_pin,
	input wire logic pll_lock_pin,
	output logic [2:0] clock_select,
	output logic switch_busy,
	output logic clock_lock,
	output logic io_lock,
	output logic fail_trap,
	output logic irq
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [2:0] active_source_code;
	logic [2:0] requested_source_code;
	logic clock_fail_flag;
	logic switch_request_bit;
	logic [7:0] switch_count;
	logic strap_loaded;
	logic [1:0] fail_sync;
	logic [1:0] lock_sync;
	logic fail_seen;
	logic [osc_ctrl_pkg::EVENT_COUNT-1:0] event_status;
	logic [osc_ctrl_pkg::EVENT_COUNT-1:0] event_mask;
	logic [osc_ctrl_pkg::EVENT_COUNT-1:0] event_set;
	logic unlocked;
	logic commit;
	logic hit_control;
	logic hit_key;
	logic hit_status;
	logic hit_mask;
	logic mapped;
	logic control_write;
	logic fail_event;
	logic fail_rise;
	logic switch_start;
	logic switch_refuse;
	logic switch_finish;
	logic pll_cross;
	logic [15:0] control_view;
	logic [31:0] next_prdata;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Address decode
	always_comb begin
		hit_control = 1'b0;
		hit_key = 1'b0;
		hit_status = 1'b0;
		hit_mask = 1'b0;
		if (paddr == osc_ctrl_pkg::OFFSET_CONTROL)
			hit_control = 1'b1;
		else if (paddr == osc_ctrl_pkg::OFFSET_KEY)
			hit_key = 1'b1;
		else if (paddr == osc_ctrl_pkg::OFFSET_EVENT_STATUS)
			hit_status = 1'b1;
		else if (paddr == osc_ctrl_pkg::OFFSET_EVENT_MASK)
			hit_mask = 1'b1;
	end

	assign mapped = hit_control | hit_key | hit_status | hit_mask;
	assign commit = psel & penable & pready & pwrite & mapped;
	assign control_write = commit & hit_control & unlocked;

	// One wait state: data and response prepared, then pready rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			prdata <= pwrite ? 32'h00000000 : next_prdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Register view; unimplemented bits read as zero
	always_comb begin
		control_view = 16'h0000;
		control_view[osc_ctrl_pkg::ACTIVE_LSB +: 3] = active_source_code;
		control_view[osc_ctrl_pkg::REQUESTED_LSB +: 3] = requested_source_code;
		control_view[osc_ctrl_pkg::CLOCK_LOCK_BIT] = clock_lock;
		control_view[osc_ctrl_pkg::IO_LOCK_BIT] = io_lock;
		control_view[osc_ctrl_pkg::PLL_LOCK_BIT] = lock_sync[1];
		control_view[osc_ctrl_pkg::FAIL_FLAG_BIT] = clock_fail_flag;
		control_view[osc_ctrl_pkg::SWITCH_REQUEST_BIT] = switch_request_bit;
		next_prdata = 32'h00000000;
		if (hit_control)
			next_prdata = {16'h0000, control_view};
		else if (hit_status)
			next_prdata = {29'h00000000, event_status};
		else if (hit_mask)
			next_prdata = {29'h00000000, event_mask};
	end

	// Unlock sequence tracker
	osc_unlock_seq u_unlock (
		.pclk(pclk),
		.presetn(presetn),
		.key_write(commit & hit_key),
		.key_data(pwdata[7:0]),
		.other_write(commit & (hit_status | hit_mask)),
		.control_write(commit & hit_control),
		.unlocked(unlocked)
	);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two flops on each asynchronous pin, then edge of the failure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_sync <= 2'b00;
			lock_sync <= 2'b00;
			fail_seen <= 1'b0;
		end else begin
			fail_sync <= {fail_sync[0], osc_fail_pin};
			lock_sync <= {lock_sync[0], pll_lock_pin};
			fail_seen <= fail_sync[1];
		end
	end

	assign fail_rise = fail_sync[1] & ~fail_seen;
	// Software writing one behaves as a genuine failure
	assign fail_event = fail_rise |
		(control_write & pwdata[osc_ctrl_pkg::FAIL_FLAG_BIT]);

	// ---------------------------------------------------------------
	// Clock-fail flag and trap
	// ---------------------------------------------------------------
	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			clock_fail_flag <= 1'b0;
		else if (fail_event)
			clock_fail_flag <= 1'b1;
		else if (control_write)
			clock_fail_flag <= 1'b0;
	end

	// One-cycle trap pulse on every failure event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fail_trap <= 1'b0;
		else
			fail_trap <= fail_event;
	end

	// ---------------------------------------------------------------
	// Control fields
	// ---------------------------------------------------------------
	// Strap value taken at the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_loaded <= 1'b0;
			requested_source_code <= osc_ctrl_pkg::RESET_SOURCE;
			clock_lock <= 1'b0;
			io_lock <= 1'b0;
		end else if (!strap_loaded) begin
			strap_loaded <= 1'b1;
			requested_source_code <= strap_source_code;
		end else if (control_write) begin
			io_lock <= pwdata[osc_ctrl_pkg::IO_LOCK_BIT];
			if (!clock_lock) begin
				clock_lock <= pwdata[osc_ctrl_pkg::CLOCK_LOCK_BIT];
				requested_source_code <=
					pwdata[osc_ctrl_pkg::REQUESTED_LSB +: 3];
			end
		end
	end

	// ---------------------------------------------------------------
	// Clock switch sequencer
	// ---------------------------------------------------------------
	// Crossing between the PLL modes must go through a source other than a PLL mode
	assign pll_cross =
		(active_source_code == osc_ctrl_pkg::PRIMARY_PLL_MODE &&
		requested_source_code == osc_ctrl_pkg::FAST_RC_PLL_MODE) ||
		(active_source_code == osc_ctrl_pkg::FAST_RC_PLL_MODE &&
		requested_source_code == osc_ctrl_pkg::PRIMARY_PLL_MODE);
	assign switch_refuse = switch_request_bit && !switch_busy &&
		(pll_cross || clock_lock ||
		requested_source_code == osc_ctrl_pkg::RESERVED_SOURCE);
	assign switch_start = switch_request_bit && !switch_busy &&
		!switch_refuse;
	assign switch_finish = switch_busy && switch_count == 8'h00;

	// Request bit: set by an unlocked write, cleared by hardware
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			switch_request_bit <= 1'b0;
		else if (switch_refuse || switch_finish)
			switch_request_bit <= 1'b0;
		else if (control_write &&
				pwdata[osc_ctrl_pkg::SWITCH_REQUEST_BIT])
			switch_request_bit <= 1'b1;
	end

	// Settling count, then the active source follows the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_busy <= 1'b0;
			switch_count <= 8'h00;
			active_source_code <= osc_ctrl_pkg::RESET_SOURCE;
			clock_select <= osc_ctrl_pkg::RESET_SOURCE;
		end else if (!strap_loaded) begin
			active_source_code <= strap_source_code;
			clock_select <= strap_source_code;
		end else if (switch_start) begin
			switch_busy <= 1'b1;
			switch_count <= 8'(SWITCH_CYCLES - 1);
			clock_select <= requested_source_code;
		end else if (switch_finish) begin
			switch_busy <= 1'b0;
			active_source_code <= clock_select;
		end else if (switch_busy) begin
			switch_count <= switch_count - 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Events and interrupt
	// ---------------------------------------------------------------
	always_comb begin
		event_set = '0;
		event_set[osc_ctrl_pkg::EVENT_SWITCH_DONE] = switch_finish;
		event_set[osc_ctrl_pkg::EVENT_SWITCH_REJECTED] = switch_refuse;
		event_set[osc_ctrl_pkg::EVENT_CLOCK_FAIL] = fail_event;
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			event_status <= '0;
		else if (commit && hit_status)
			event_status <= (event_status &
				~pwdata[osc_ctrl_pkg::EVENT_COUNT-1:0]) | event_set;
		else
			event_status <= event_status | event_set;
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			event_mask <= '0;
		else if (commit && hit_mask)
			event_mask <= pwdata[osc_ctrl_pkg::EVENT_COUNT-1:0];
	end

	// Level interrupt from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(event_status & event_mask);
	end

endmodule : osc_ctrl

/* File: testbench/osc_ctrl_assertions.sv */
/*
 * Port-level checker for the oscillator source select block.
 * Assumes it is bound to osc_ctrl and sees only that module's ports.
 */
`timescale 1ns/1ps

module osc_ctrl_chk #(
	parameter int SWITCH_CYCLES = osc_ctrl_pkg::SWITCH_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_fail_pin,
	input wire logic [2:0] clock_select,
	input wire logic switch_busy,
	input wire logic fail_trap
);
	logic [7:0] busy_cnt;

	// Counts the cycles of the current settling period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt <= 8'h00;
		else
			busy_cnt <= switch_busy ? busy_cnt + 8'h01 : 8'h00;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_addr_err: assert property (pready && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > 8'h0C))
		else $error("pslverr does not match address map");
	chk_trap_pulse: assert property (fail_trap |=> !fail_trap)
		else $error("trap longer than one cycle");
	chk_pin_trap: assert property ($rose(osc_fail_pin) |-> ##[1:6] fail_trap)
		else $error("pin failure raised no trap");
	chk_busy_len: assert property ($fell(switch_busy)
		|-> busy_cnt == 8'(SWITCH_CYCLES))
		else $error("settling period has wrong length");
	chk_select_hold: assert property (switch_busy && $past(switch_busy)
		|-> $stable(clock_select))
		else $error("clock select moved while settling");
	chk_select_cause: assert property ($changed(clock_select)
		&& $past(presetn, 2) |-> switch_busy)
		else $error("clock select changed outside a switch");
	chk_no_pll_cross: assert property ($changed(clock_select)
		|-> {$past(clock_select), clock_select} != 6'h19
		&& {$past(clock_select), clock_select} != 6'h0B)
		else $error("direct switch between pll modes");
endmodule : osc_ctrl_chk

bind osc_ctrl osc_ctrl_chk #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_chk (
	.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
	.osc_fail_pin, .clock_select, .switch_busy, .fail_trap);

/* File: testbench/tb.sv */
/*
 * Self-checking bench for the oscillator source select block.
 * Assumes the checker is bound in; drives APB and the failure pin.
 */
`timescale 1ns/1ps

module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic osc_fail_pin = 1'b0;
	logic [2:0] clock_select;
	logic switch_busy, clock_lock, io_lock, fail_trap, irq;
	int error_cnt = 0;
	int n_checks = 0;
	int traps = 0;
	int t0;
	logic [31:0] rd;
	logic err;
	logic [2:0] cur = 3'h2;
	int codes [13] = '{1, 0, 3, 1, 0, 1, 3, 0, 5, 6, 7, 4, 2};
	logic [12:0] oks = 13'b1110110111101;

	osc_ctrl #(.SWITCH_CYCLES(2)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.strap_source_code(3'h2), .osc_fail_pin, .pll_lock_pin(1'b1),
		.clock_select, .switch_busy, .clock_lock, .io_lock, .fail_trap, .irq);

	// Clock and trap pulse counter
	always #2 pclk = ~pclk;
	always @(posedge pclk) if (fail_trap === 1'b1) traps <= traps + 1;

	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task wrap_up;
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			error_cnt++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Unlock keys then one control write
	task uw(input logic [31:0] d);
		apb(1'b1, osc_ctrl_pkg::OFFSET_KEY, {24'h0, osc_ctrl_pkg::KEY_FIRST});
		apb(1'b1, osc_ctrl_pkg::OFFSET_KEY, {24'h0, osc_ctrl_pkg::KEY_SECOND});
		apb(1'b1, osc_ctrl_pkg::OFFSET_CONTROL, d);
	endtask : uw

	// Requests a switch, also trying to write the read-only active field
	task sw(input logic [2:0] code, input logic ok);
		int n;
		uw({17'h0, 3'h7, 1'b0, code, 8'h01});
		n = 0;
		do begin
			apb(1'b0, osc_ctrl_pkg::OFFSET_EVENT_STATUS, 32'h0);
			n++;
		end while (rd[1:0] == 2'h0 && n < 30);
		chk("status", rd, ok ? 32'h1 : 32'h2);
		if (ok) cur = code;
		chk("select", {29'h0, clock_select}, {29'h0, cur});
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("control", rd, {17'h0, cur, 1'b0, code, 8'h20});
		apb(1'b1, osc_ctrl_pkg::OFFSET_EVENT_STATUS, 32'h7);
	endtask : sw

	// Software and pin failures, flag, trap and interrupt
	task t_fail;
		apb(1'b1, osc_ctrl_pkg::OFFSET_EVENT_MASK, 32'h4);
		t0 = traps;
		uw({21'h0, cur, 8'h08});
		repeat (4) @(posedge pclk);
		chk("sw trap", 32'(traps - t0), 32'h1);
		chk("irq set", {31'h0, irq}, 32'h1);
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("flag", rd, {17'h0, cur, 1'b0, cur, 8'h28});
		apb(1'b1, osc_ctrl_pkg::OFFSET_EVENT_STATUS, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq clear", {31'h0, irq}, 32'h0);
		uw({21'h0, cur, 8'h00});
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("flag clear", rd, {17'h0, cur, 1'b0, cur, 8'h20});
		apb(1'b1, osc_ctrl_pkg::OFFSET_EVENT_MASK, 32'h0);
		t0 = traps;
		osc_fail_pin <= 1'b1;
		repeat (20) @(posedge pclk);
		chk("pin trap", 32'(traps - t0), 32'h1);
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("pin flag", rd, {17'h0, cur, 1'b0, cur, 8'h28});
		apb(1'b0, osc_ctrl_pkg::OFFSET_EVENT_STATUS, 32'h0);
		chk("pin status", rd, 32'h4);
		chk("irq masked", {31'h0, irq}, 32'h0);
		osc_fail_pin <= 1'b0;
	endtask : t_fail

	// Clock lock refuses a switch and holds the request; io lock stays free
	task t_lock;
		apb(1'b1, osc_ctrl_pkg::OFFSET_EVENT_STATUS, 32'h7);
		uw({21'h0, cur, 8'hC0});
		chk("locks", {30'h0, clock_lock, io_lock}, 32'h3);
		uw({21'h0, 3'h0, 8'h01});
		repeat (3) @(posedge pclk);
		apb(1'b0, osc_ctrl_pkg::OFFSET_EVENT_STATUS, 32'h0);
		chk("lock status", rd, 32'h2);
		chk("lock select", {29'h0, clock_select}, {29'h0, cur});
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("lock control", rd, {17'h0, cur, 1'b0, cur, 8'hA0});
	endtask : t_lock

	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("reset control", rd, 32'h2220);
		apb(1'b1, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0501);
		apb(1'b1, osc_ctrl_pkg::OFFSET_KEY, {24'h0, osc_ctrl_pkg::KEY_FIRST});
		apb(1'b1, osc_ctrl_pkg::OFFSET_EVENT_MASK, 32'h0);
		apb(1'b1, osc_ctrl_pkg::OFFSET_KEY, {24'h0, osc_ctrl_pkg::KEY_SECOND});
		apb(1'b1, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0501);
		apb(1'b0, osc_ctrl_pkg::OFFSET_CONTROL, 32'h0);
		chk("locked", rd, 32'h2220);
		for (int i = 0; i < 13; i++)
			sw(3'(codes[i]), oks[12 - i]);
		t_fail();
		t_lock();
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'b0, osc_ctrl_pkg::OFFSET_KEY, 32'h0);
		chk("key read", rd, 32'h0);
		wrap_up();
	end

	// Watchdog
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end
endmodule : tb
